//--- cspi_pkg.sv
// constants and functions for the core status, power and irq enable block
// Contract
// - status bit 5 is a free user flag
// - status bit 1 is a second free flag
// - bank select bits 4:3 pick RAM bank
// - doubler doubles timer 1 baud in modes 1-3
// - global enable low blocks every interrupt; the block event irq output is not gated by it
// - with global enable, per-source bits gate sources
// - timer 1 request gated by its enable bit
// - accepted interrupt fetches its fixed vector
// - trigger select 0 level, 1 falling transition
`default_nettype none
package cspi_pkg;
  // register byte offsets on the axi4-lite slave
  localparam logic [7:0] CSPI_OFF_STW = 8'h00;
  localparam logic [7:0] CSPI_OFF_PWRC = 8'h04;
  localparam logic [7:0] CSPI_OFF_IEN = 8'h08;
  localparam logic [7:0] CSPI_OFF_TRIG = 8'h0c;
  localparam logic [7:0] CSPI_OFF_EVT_STAT = 8'h10;
  localparam logic [7:0] CSPI_OFF_EVT_CLR = 8'h14;
  localparam logic [7:0] CSPI_OFF_EVT_EN = 8'h18;
  localparam logic [7:0] CSPI_OFF_VEC = 8'h1c;
  // values after reset
  localparam logic [7:0] CSPI_RST_STW = 8'h00;
  localparam logic [7:0] CSPI_RST_PWRC = 8'h00;
  localparam logic [7:0] CSPI_RST_IEN = 8'h00;
  // status word fields
  localparam int CSPI_STW_CARRY = 7;
  localparam int CSPI_STW_AUXC = 6;
  localparam int CSPI_STW_UF0 = 5;
  localparam int CSPI_STW_RS_LO = 3;
  localparam int CSPI_STW_WRAP = 2;
  localparam int CSPI_STW_UF1 = 1;
  localparam int CSPI_STW_PAR = 0;
  // power control fields and writable mask
  localparam int CSPI_PWRC_DBL = 7;
  localparam int CSPI_PWRC_PDN = 1;
  localparam int CSPI_PWRC_PAUSE = 0;
  localparam logic [7:0] CSPI_PWRC_MASK = 8'h8f;
  // interrupt enable fields and writable mask
  localparam int CSPI_IEN_GLOBAL = 7;
  localparam logic [7:0] CSPI_IEN_MASK = 8'hbf;
  // source indices, in fixed priority order
  localparam int CSPI_NSRC = 6;
  localparam int CSPI_SRC_T1 = 3;
  // vector map: first vector and stride between sources
  localparam logic [15:0] CSPI_VEC_BASE = 16'h0003;
  localparam int CSPI_VEC_STRIDE = 8;
  // event status bits
  localparam int CSPI_EVT_IDLE = 0;
  localparam int CSPI_EVT_PDN = 1;
  localparam int CSPI_EVT_ACK = 2;
  localparam int CSPI_NEVT = 3;
  // axi responses
  localparam logic [1:0] CSPI_RESP_OKAY = 2'h0;
  localparam logic [1:0] CSPI_RESP_SLVERR = 2'h2;
  // vector address of a source index
  function automatic logic [15:0] cspi_vec_of(input logic [2:0] idx);
    cspi_vec_of = CSPI_VEC_BASE + 16'(idx) * 16'(CSPI_VEC_STRIDE);
  endfunction
  // odd parity over a byte
  function automatic logic cspi_parity(input logic [7:0] v);
    cspi_parity = ^v;
  endfunction
endpackage
`default_nettype wire

//--- cspi_irq_if.sv
// interface between the register bank and the interrupt selector
`timescale 1ns/1ps
`default_nettype none
interface cspi_irq_if;
  logic [7:0] enable_mask; // interrupt enable register value
  logic [1:0] trigger_sel; // ext1, ext0 trigger select bits
  logic ack; // core vectors to the pending request
  logic req; // an enabled request is pending
  logic [15:0] vector; // vector of the pending request
  logic [2:0] src; // index of the pending request
  logic [1:0] ext_pending; // ext1, ext0 latched falling-edge flags
  modport ctl (output enable_mask, output trigger_sel, output ack,
    input req, input vector, input src, input ext_pending);
  modport sel (input enable_mask, input trigger_sel, input ack,
    output req, output vector, output src, output ext_pending);
endinterface
`default_nettype wire

//--- cspi_irq_select.sv
// interrupt source gating, external trigger and vector selection
`timescale 1ns/1ps
`default_nettype none
module cspi_irq_select
  import cspi_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bank side
  cspi_irq_if.sel bus,
  // external request pins, active low
  input wire logic ext0_request_pin_n,
  input wire logic ext1_request_pin_n,
  // peripheral pending flags
  input wire logic timer0_wrap_pending,
  input wire logic timer1_wrap_pending,
  input wire logic timer2_wrap_pending,
  input wire logic timer2_ext_pending,
  input wire logic uart_rx_done,
  input wire logic uart_tx_done
);
  logic [1:0] pin_prev_reg; // last sampled pin levels
  logic [1:0] pin_prev_next;
  logic [1:0] edge_reg; // latched falling edges
  logic [1:0] edge_next;
  logic req_reg; // registered request
  logic req_next;
  logic [15:0] vec_reg; // registered vector
  logic [15:0] vec_next;
  logic [2:0] src_reg; // registered source index
  logic [2:0] src_next;
  logic [1:0] pins_n; // current pin levels
  logic [1:0] ext_pend; // external pending per trigger mode
  logic [CSPI_NSRC-1:0] raw; // pending sources in priority order
  logic [CSPI_NSRC-1:0] live; // pending and enabled

  assign pins_n = {ext1_request_pin_n, ext0_request_pin_n};

  // next state for edge capture and selection
  always_comb
  begin
    pin_prev_next = pins_n;
    edge_next = edge_reg;
    for (int k = 0; k < 2; k++)
    begin
      // clear as the core vectors to this source
      if (bus.ack && req_reg && src_reg == 3'(2 * k))
        edge_next[k] = 1'b0;
      // latch only in transition mode, so no stale edge follows a switch
      if (bus.trigger_sel[k] && pin_prev_reg[k] && !pins_n[k])
        edge_next[k] = 1'b1;
    end
    // level mode follows the low pin, transition mode the latch
    for (int k = 0; k < 2; k++)
      ext_pend[k] = bus.trigger_sel[k] ? edge_reg[k] : !pins_n[k];
    raw = {timer2_wrap_pending | timer2_ext_pending,
      uart_rx_done | uart_tx_done, timer1_wrap_pending,
      ext_pend[1], timer0_wrap_pending, ext_pend[0]};
    // per-source enables behind the global enable
    live = raw & bus.enable_mask[CSPI_NSRC-1:0];
    if (!bus.enable_mask[CSPI_IEN_GLOBAL])
      live = '0;
    req_next = |live;
    src_next = 3'h0;
    // lowest index has highest priority
    for (int k = CSPI_NSRC - 1; k >= 0; k--)
      if (live[k])
        src_next = 3'(k);
    vec_next = cspi_vec_of(src_next);
  end

  // register the selection
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_prev_reg <= 2'h3;
      edge_reg <= 2'h0;
      req_reg <= 1'b0;
      vec_reg <= 16'h0000;
      src_reg <= 3'h0;
    end
    else
    begin
      pin_prev_reg <= pin_prev_next;
      edge_reg <= edge_next;
      req_reg <= req_next;
      vec_reg <= vec_next;
      src_reg <= src_next;
    end
  end

  assign bus.req = req_reg;
  assign bus.vector = vec_reg;
  assign bus.src = src_reg;
  assign bus.ext_pending = edge_reg;

  AST_GLOBAL_BLOCKS: assert property (@(posedge aclk) disable iff (!aresetn)
    !bus.enable_mask[CSPI_IEN_GLOBAL] |=> !req_reg)
    else $error("request raised while global enable low");
  AST_T1_GATED: assert property (@(posedge aclk) disable iff (!aresetn)
    !bus.enable_mask[CSPI_SRC_T1] |=> src_reg != 3'(CSPI_SRC_T1)
      || !req_reg)
    else $error("timer 1 selected while its enable is low");
  AST_VECTOR_MAP: assert property (@(posedge aclk) disable iff (!aresetn)
    req_reg |-> vec_reg == 16'h0003 + 16'(src_reg) * 16'h0008)
    else $error("vector does not match source");
  AST_EDGE_LATCH: assert property (@(posedge aclk) disable iff (!aresetn)
    bus.trigger_sel[0] && pin_prev_reg[0] && !pins_n[0]
      |=> edge_reg[0])
    else $error("falling edge on ext0 not latched");
endmodule
`default_nettype wire

//--- cspi_core_regs.sv
// status word, power control and interrupt enable registers, axi4-lite
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module cspi_core_regs
  import cspi_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // core datapath side
  input wire logic [7:0] acc_value,
  input wire logic flag_update,
  input wire logic carry_flag_in,
  input wire logic aux_carry_flag_in,
  input wire logic signed_wrap_flag_in,
  output logic [7:0] bank_base,
  // serial baud control
  input wire logic timer1_baud_src,
  input wire logic [1:0] uart_mode,
  output logic baud_double,
  // power state
  output logic idle_mode,
  output logic power_down_mode,
  // interrupt sources
  input wire logic ext0_request_pin_n,
  input wire logic ext1_request_pin_n,
  input wire logic timer0_wrap_pending,
  input wire logic timer1_wrap_pending,
  input wire logic timer2_wrap_pending,
  input wire logic timer2_ext_pending,
  input wire logic uart_rx_done,
  input wire logic uart_tx_done,
  // core vectoring
  input wire logic irq_ack,
  output logic irq_request,
  output logic [15:0] irq_vector,
  output logic ext0_pending,
  output logic ext1_pending,
  // block event interrupt
  output logic irq
);
  cspi_irq_if sel_if(); // link to the selector

  // register state
  logic [7:0] stw_reg; // status word, bit 0 from parity
  logic [7:0] stw_next;
  logic [7:0] pwrc_reg; // power control
  logic [7:0] pwrc_next;
  logic [7:0] ien_reg; // interrupt enable mask
  logic [7:0] ien_next;
  logic [1:0] trig_reg; // ext1, ext0 trigger select
  logic [1:0] trig_next;
  logic [CSPI_NEVT-1:0] evt_reg; // sticky events
  logic [CSPI_NEVT-1:0] evt_next;
  logic [CSPI_NEVT-1:0] evt_en_reg; // event enables
  logic [CSPI_NEVT-1:0] evt_en_next;
  logic baud_reg; // registered doubler output
  logic baud_next;
  logic [7:0] bank_reg; // registered bank base address
  logic [7:0] bank_next;

  // bus state
  logic aw_have_reg; // write address held
  logic aw_have_next;
  logic [7:0] aw_addr_reg;
  logic [7:0] aw_addr_next;
  logic w_have_reg; // write data held
  logic w_have_next;
  logic [31:0] w_data_reg;
  logic [31:0] w_data_next;
  logic w_strb0_reg; // only byte lane 0 carries register data
  logic w_strb0_next;
  logic bvalid_reg;
  logic bvalid_next;
  logic [1:0] bresp_reg;
  logic [1:0] bresp_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [1:0] rresp_reg;
  logic [1:0] rresp_next;

  // decode helpers
  logic do_write; // both halves held, response slot free
  logic wr_hit; // write address is mapped
  logic [7:0] wbyte; // low byte of write data
  logic [7:0] rbyte; // read value before widening
  logic rd_hit; // read address is mapped
  logic ack_taken; // core vectored to a live request

  cspi_irq_select u_sel (
    .aclk(aclk),
    .aresetn(aresetn),
    .bus(sel_if),
    .ext0_request_pin_n(ext0_request_pin_n),
    .ext1_request_pin_n(ext1_request_pin_n),
    .timer0_wrap_pending(timer0_wrap_pending),
    .timer1_wrap_pending(timer1_wrap_pending),
    .timer2_wrap_pending(timer2_wrap_pending),
    .timer2_ext_pending(timer2_ext_pending),
    .uart_rx_done(uart_rx_done),
    .uart_tx_done(uart_tx_done)
  );

  assign sel_if.enable_mask = ien_reg;
  assign sel_if.trigger_sel = trig_reg;
  assign sel_if.ack = irq_ack;
  assign ack_taken = irq_ack && sel_if.req;

  // write address decode
  assign do_write = aw_have_reg && w_have_reg && !bvalid_reg;
  assign wbyte = w_strb0_reg ? w_data_reg[7:0] : 8'h00;
  always_comb
  begin
    case (aw_addr_reg)
      CSPI_OFF_STW, CSPI_OFF_PWRC, CSPI_OFF_IEN, CSPI_OFF_TRIG,
      CSPI_OFF_EVT_STAT, CSPI_OFF_EVT_CLR, CSPI_OFF_EVT_EN,
      CSPI_OFF_VEC: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // axi channel state: address and data taken in either order
  always_comb
  begin
    aw_have_next = aw_have_reg;
    aw_addr_next = aw_addr_reg;
    w_have_next = w_have_reg;
    w_data_next = w_data_reg;
    w_strb0_next = w_strb0_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_have_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_have_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb0_next = s_axi_wstrb[0];
    end
    if (do_write)
    begin
      // response after both halves, unmapped answers slverr
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = wr_hit ? CSPI_RESP_OKAY : CSPI_RESP_SLVERR;
    end
    else if (bvalid_reg && s_axi_bready)
      bvalid_next = 1'b0;
  end

  // read channel: one read at a time, data from flip-flops
  always_comb
  begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      CSPI_OFF_STW: rbyte = stw_reg;
      CSPI_OFF_PWRC: rbyte = pwrc_reg;
      CSPI_OFF_IEN: rbyte = ien_reg;
      CSPI_OFF_TRIG: rbyte = {6'h00, trig_reg};
      CSPI_OFF_EVT_STAT: rbyte = 8'(evt_reg);
      CSPI_OFF_EVT_CLR: rbyte = 8'h00; // write-only, reads zero
      CSPI_OFF_EVT_EN: rbyte = 8'(evt_en_reg);
      CSPI_OFF_VEC: rbyte = {sel_if.req, sel_if.ext_pending,
        2'h0, sel_if.src};
      default:
      begin
        rbyte = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_next = 1'b1;
      rdata_next = {24'h000000, rbyte};
      rresp_next = rd_hit ? CSPI_RESP_OKAY : CSPI_RESP_SLVERR;
    end
    else if (rvalid_reg && s_axi_rready)
      rvalid_next = 1'b0;
  end

  // register bank next values
  always_comb
  begin
    stw_next = stw_reg;
    pwrc_next = pwrc_reg;
    ien_next = ien_reg;
    trig_next = trig_reg;
    evt_en_next = evt_en_reg;
    evt_next = evt_reg;
    if (do_write && wr_hit)
    begin
      case (aw_addr_reg)
        // software owns user flags, bank select and arithmetic flags
        CSPI_OFF_STW: stw_next = wbyte;
        CSPI_OFF_PWRC:
        begin
          // unimplemented bits are dropped; software keeps them zero
          pwrc_next = wbyte & CSPI_PWRC_MASK;
          if (wbyte[CSPI_PWRC_PDN])
            pwrc_next[CSPI_PWRC_PAUSE] = 1'b0;
        end
        CSPI_OFF_IEN: ien_next = wbyte & CSPI_IEN_MASK;
        CSPI_OFF_TRIG: trig_next = wbyte[1:0];
        CSPI_OFF_EVT_CLR: evt_next = evt_reg & ~wbyte[CSPI_NEVT-1:0];
        CSPI_OFF_EVT_EN: evt_en_next = wbyte[CSPI_NEVT-1:0];
        default: stw_next = stw_reg;
      endcase
    end
    // arithmetic flags from the datapath override a bus write
    if (flag_update)
    begin
      stw_next[CSPI_STW_CARRY] = carry_flag_in;
      stw_next[CSPI_STW_AUXC] = aux_carry_flag_in;
      stw_next[CSPI_STW_WRAP] = signed_wrap_flag_in;
    end
    // parity follows the accumulator every cycle
    stw_next[CSPI_STW_PAR] = cspi_parity(acc_value);
    // an interrupt request wakes the core from idle
    if (sel_if.req)
      pwrc_next[CSPI_PWRC_PAUSE] = 1'b0;
    // sticky events: a set in the clearing cycle wins
    if (!pwrc_reg[CSPI_PWRC_PAUSE] && pwrc_next[CSPI_PWRC_PAUSE])
      evt_next[CSPI_EVT_IDLE] = 1'b1;
    if (!pwrc_reg[CSPI_PWRC_PDN] && pwrc_next[CSPI_PWRC_PDN])
      evt_next[CSPI_EVT_PDN] = 1'b1;
    if (ack_taken)
      evt_next[CSPI_EVT_ACK] = 1'b1;
    // doubler only with timer 1 as baud source in modes 1, 2, 3
    baud_next = pwrc_reg[CSPI_PWRC_DBL] && timer1_baud_src
      && uart_mode != 2'h0;
    // working bank base is bank number times eight
    bank_next = {3'h0, stw_reg[CSPI_STW_RS_LO +: 2], 3'h0};
  end

  // register all state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stw_reg <= CSPI_RST_STW;
      pwrc_reg <= CSPI_RST_PWRC;
      ien_reg <= CSPI_RST_IEN;
      trig_reg <= 2'h0;
      evt_reg <= '0;
      evt_en_reg <= '0;
      baud_reg <= 1'b0;
      bank_reg <= 8'h00;
      aw_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_have_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb0_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= CSPI_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= CSPI_RESP_OKAY;
    end
    else
    begin
      stw_reg <= stw_next;
      pwrc_reg <= pwrc_next;
      ien_reg <= ien_next;
      trig_reg <= trig_next;
      evt_reg <= evt_next;
      evt_en_reg <= evt_en_next;
      baud_reg <= baud_next;
      bank_reg <= bank_next;
      aw_have_reg <= aw_have_next;
      aw_addr_reg <= aw_addr_next;
      w_have_reg <= w_have_next;
      w_data_reg <= w_data_next;
      w_strb0_reg <= w_strb0_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  // bus handshake outputs
  assign s_axi_awready = !aw_have_reg && !bvalid_reg;
  assign s_axi_wready = !w_have_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // core side outputs
  assign bank_base = bank_reg;
  assign baud_double = baud_reg;
  assign idle_mode = pwrc_reg[CSPI_PWRC_PAUSE];
  assign power_down_mode = pwrc_reg[CSPI_PWRC_PDN];
  assign irq_request = sel_if.req;
  assign irq_vector = sel_if.vector;
  assign ext0_pending = sel_if.ext_pending[0];
  assign ext1_pending = sel_if.ext_pending[1];
  assign irq = |(evt_reg & evt_en_reg);

  // a status word write seen by the bus
  sequence s_stw_write;
    do_write && wr_hit && aw_addr_reg == CSPI_OFF_STW && w_strb0_reg;
  endsequence

  AST_USER_FLAGS: assert property (@(posedge aclk) disable iff (!aresetn)
    s_stw_write |=> stw_reg[CSPI_STW_UF0] == $past(wbyte[5])
      && stw_reg[CSPI_STW_UF1] == $past(wbyte[1]))
    else $error("user flags not stored from write");
  AST_BANK_BASE: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 bank_base == {3'h0, $past(stw_reg[4:3]), 3'h0})
    else $error("bank base does not follow bank select");
  AST_BAUD: assert property (@(posedge aclk) disable iff (!aresetn)
    pwrc_reg[7] && timer1_baud_src && uart_mode == 2'h0
      |=> !baud_double)
    else $error("doubler active in mode 0");
  AST_PARITY: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 stw_reg[0] == ^$past(acc_value))
    else $error("parity flag does not match accumulator");
  AST_PDN_WINS: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && aw_addr_reg == CSPI_OFF_PWRC && w_strb0_reg
      && wbyte[1:0] == 2'h3 |=> power_down_mode && !idle_mode)
    else $error("idle taken alongside power-down");
  AST_PWRC_RSVD: assert property (@(posedge aclk) disable iff (!aresetn)
    pwrc_reg[6:4] == 3'h0 && ien_reg[6] == 1'b0)
    else $error("reserved bit holds a one");
endmodule
`default_nettype wire

//--- test_core_status_power_irq_enable.sv
// self-checking bench for the core status, power and irq enable block
`timescale 1ns/1ps
`default_nettype none
module test_core_status_power_irq_enable;
  import cspi_pkg::*;
  // run limit in cycles; the whole sequence needs a few hundred
  localparam int LIMIT = 20000;
  // bench clock and reset
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  // axi4-lite master side
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  // core side stimulus and observation
  logic [7:0] acc_value, bank_base;
  logic flag_update, carry_flag_in, aux_carry_flag_in, signed_wrap_flag_in;
  logic timer1_baud_src, baud_double, idle_mode, power_down_mode;
  logic [1:0] uart_mode;
  logic irq_ack, irq_request, ext0_pending, ext1_pending, irq;
  logic [15:0] irq_vector;
  // sources: ext0 t0 ext1 t1 rx t2wrap tx t2ext, high means active
  logic [7:0] src_v;
  // bookkeeping
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [31:0] d;
  logic [1:0] r;
  logic [7:0] w, a;
  int idx;

  always #12.5 aclk = ~aclk;

  cspi_core_regs cspi_core_regs_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .acc_value, .flag_update,
    .carry_flag_in, .aux_carry_flag_in, .signed_wrap_flag_in, .bank_base,
    .timer1_baud_src, .uart_mode, .baud_double, .idle_mode,
    .power_down_mode, .ext0_request_pin_n(~src_v[0]),
    .ext1_request_pin_n(~src_v[2]), .timer0_wrap_pending(src_v[1]),
    .timer1_wrap_pending(src_v[3]), .timer2_wrap_pending(src_v[5]),
    .timer2_ext_pending(src_v[7]), .uart_rx_done(src_v[4]),
    .uart_tx_done(src_v[6]), .irq_ack, .irq_request, .irq_vector,
    .ext0_pending, .ext1_pending, .irq
  );

  // closing report, reached from the main sequence or the watchdog
  task automatic print_verdict();
    if (mismatches == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // compare and count; an unknown bit matches only the same unknown
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // vector of a source index: 0003h plus eight per step
  function automatic logic [15:0] exp_vec(input int i);
    exp_vec = 16'h0003 + 16'(i) * 16'h0008;
  endfunction

  // ready is looked at mid-cycle, so it is the value the next edge samples
  task automatic axi_wr(input logic [7:0] ad, input logic [7:0] dt,
    output logic [1:0] rs);
    logic aw, wd, bv;
    bv = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h0, dt};
    s_axi_wstrb <= 4'h1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!bv)
    begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      wd = s_axi_wvalid && s_axi_wready;
      bv = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (wd) s_axi_wvalid <= 1'b0;
      if (bv) s_axi_bready <= 1'b0;
    end
  endtask

  task automatic axi_rd(input logic [7:0] ad, output logic [31:0] dt,
    output logic [1:0] rs);
    logic ar, rv;
    rv = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!rv)
    begin
      @(negedge aclk);
      ar = s_axi_arvalid && s_axi_arready;
      rv = s_axi_rvalid;
      dt = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
      if (rv) s_axi_rready <= 1'b0;
    end
  endtask

  // let registered outputs settle, then look mid-cycle
  task automatic wait_n(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask

  // one-cycle acknowledge from the core
  task automatic ack_pulse();
    @(posedge aclk) irq_ack <= 1'b1;
    @(posedge aclk) irq_ack <= 1'b0;
    wait_n(3);
  endtask

  // watchdog against a hung handshake
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      mismatches++;
      print_verdict();
    end
  end

  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, flag_update, irq_ack} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {carry_flag_in, aux_carry_flag_in, signed_wrap_flag_in} = 3'h0;
    {acc_value, src_v, timer1_baud_src, uart_mode} = '0;
    void'($urandom(32'hfafae536));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    // values after reset
    axi_rd(CSPI_OFF_STW, d, r);
    chk(d, {24'h0, CSPI_RST_STW});
    axi_rd(CSPI_OFF_PWRC, d, r);
    chk(d, {24'h0, CSPI_RST_PWRC});
    axi_rd(CSPI_OFF_IEN, d, r);
    chk(d, {24'h0, CSPI_RST_IEN});
    // status word: free flags, every bank, parity beats the write
    for (int i = 0; i < 4; i++)
    begin
      w = 8'($urandom);
      w[4:3] = 2'(i);
      a = 8'($urandom);
      @(posedge aclk) acc_value <= a;
      axi_wr(CSPI_OFF_STW, w, r);
      axi_rd(CSPI_OFF_STW, d, r);
      chk(d, {24'h0, w[7:1], ^a});
      chk(bank_base, {27'h0, w[4:3], 3'h0});
    end
    // datapath flag load
    @(posedge aclk) {carry_flag_in, aux_carry_flag_in} <= 2'b10;
    signed_wrap_flag_in <= 1'b1;
    flag_update <= 1'b1;
    @(posedge aclk) flag_update <= 1'b0;
    axi_rd(CSPI_OFF_STW, d, r);
    chk({d[7], d[6], d[2]}, 3'b101);
    // gating and vectors per source, level mode on the pins
    axi_wr(CSPI_OFF_TRIG, 8'h00, r);
    for (int i = 0; i < 8; i++)
    begin
      idx = (i < 6) ? i : i - 2;
      @(posedge aclk) src_v <= 8'h01 << i;
      axi_wr(CSPI_OFF_IEN, 8'h80 | (8'h3f & ~(8'h01 << idx)), r);
      wait_n(3);
      chk(irq_request, 1'b0);
      axi_wr(CSPI_OFF_IEN, 8'h80 | (8'h01 << idx), r);
      wait_n(3);
      chk(irq_request, 1'b1);
      chk(irq_vector, exp_vec(idx));
      axi_wr(CSPI_OFF_IEN, 8'h3f, r);
      wait_n(3);
      chk(irq_request, 1'b0);
    end
    // falling-edge mode on both pins: each acknowledge consumes one latch
    @(posedge aclk) src_v <= 8'h00;
    axi_wr(CSPI_OFF_TRIG, 8'h03, r);
    axi_wr(CSPI_OFF_IEN, 8'h85, r);
    @(posedge aclk) src_v <= 8'h05;
    wait_n(3);
    chk({irq_request, ext1_pending, ext0_pending}, 3'b111);
    chk(irq_vector, exp_vec(0));
    ack_pulse();
    chk({irq_request, ext1_pending, ext0_pending}, 3'b110);
    chk(irq_vector, exp_vec(2));
    ack_pulse();
    chk(irq_request, 1'b0);
    chk(irq, 1'b0);
    axi_rd(CSPI_OFF_EVT_STAT, d, r);
    chk(d & 32'h4, 32'h4);
    axi_wr(CSPI_OFF_EVT_EN, 8'h04, r);
    wait_n(1);
    chk(irq, 1'b1);
    axi_wr(CSPI_OFF_EVT_CLR, 8'h04, r);
    wait_n(1);
    chk(irq, 1'b0);
    // level mode: request stays while the pin stays low
    axi_wr(CSPI_OFF_TRIG, 8'h00, r);
    ack_pulse();
    chk(irq_request, 1'b1);
    @(posedge aclk) src_v <= 8'h00;
    axi_wr(CSPI_OFF_IEN, 8'h00, r);
    axi_wr(CSPI_OFF_EVT_CLR, 8'h07, r);
    // power-down written with idle, then idle alone
    axi_wr(CSPI_OFF_PWRC, 8'h03, r);
    wait_n(1);
    chk({power_down_mode, idle_mode}, 2'b10);
    axi_rd(CSPI_OFF_PWRC, d, r);
    chk(d, 32'h02);
    axi_wr(CSPI_OFF_PWRC, 8'h01, r);
    wait_n(1);
    chk({power_down_mode, idle_mode}, 2'b01);
    axi_rd(CSPI_OFF_EVT_STAT, d, r);
    chk(d, 32'h3);
    // doubler against baud source and serial mode
    for (int i = 0; i < 8; i++)
    begin
      w = 8'($urandom) & 8'h8c;
      @(posedge aclk) timer1_baud_src <= 1'($urandom);
      uart_mode <= 2'(i);
      axi_wr(CSPI_OFF_PWRC, w, r);
      axi_rd(CSPI_OFF_PWRC, d, r);
      chk(d, {24'h0, w});
      chk(baud_double, w[7] && timer1_baud_src && uart_mode != 2'h0);
    end
    // unmapped addresses are refused
    axi_rd(8'h20, d, r);
    chk(d, 32'h0);
    chk(r, CSPI_RESP_SLVERR);
    axi_wr(8'h24, 8'hff, r);
    chk(r, CSPI_RESP_SLVERR);
    print_verdict();
  end
endmodule
`default_nettype wire
